// *** core/hacp_command_port.sv ***
// hacp_command_port: opcode/parameter port, data-in, interrupts, scan
// assumes a synchronous register master and one clock sys_clk
// Summary of operation
// - parameter bytes follow one at a time, each after busy reads zero
// - returned bytes load data-in and set ready; a read clears it
// - opcodes 00-0B, 0D, 1A-1D, 1F, 20, 21, 81, 8D are decoded
// - opcode 00 only sets command complete
// - opcode 01 takes count then three address bytes, high byte first
// - zero mailbox count sets invalid together with complete
// - good mailbox init sets complete and clears init required
// - each mailbox entry is four bytes from the programmed base
// - opcode 02 scans outgoing entries until all are started
// - accepted scan start does not set command complete
// - scan start before mailbox init sets invalid and complete
// - opcode 03 belongs to the on-board BIOS only
// - opcode 04 returns four identification bytes via data-in
// - interrupt goes out on one selected line, default the third
// - init required is set after reset
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
module hacp_command_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input hacp_pkg::hacp_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    output logic [hacp_pkg::HACP_NUM_IRQ-1:0] irq_lines,
    output hacp_pkg::hacp_scan_t scan_out
);
    hacp_pkg::hacp_state_t state_r, state_nxt;
    logic [7:0] op_r, op_nxt;
    logic [2:0] npar_r, npar_nxt;
    logic [2:0] pidx_r, pidx_nxt;
    logic [7:0] cnt_r, cnt_nxt, cnt_fin;
    logic [31:0] base_r, base_nxt;
    logic [31:0] pbuf_r, pbuf_nxt, base_fin;
    logic mbox_init_r, mbox_init_nxt;
    logic init_req_r, init_req_nxt;
    logic busy_r, busy_nxt;
    logic dir_rdy_r, dir_rdy_nxt;
    logic [7:0] din_r, din_nxt;
    logic [1:0] sidx_r, sidx_nxt;
    logic [1:0] ist_r, ist_nxt;
    logic [1:0] ien_r, ien_nxt;
    logic [2:0] irqsel_r, irqsel_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic scan_act_r, scan_act_nxt;
    logic [7:0] sc_idx_r, sc_idx_nxt;
    hacp_pkg::hacp_scan_t scan_r, scan_nxt;
    logic cmd_wr, din_rd, scan_req, adapter_ready, irq_any;
    logic cc_set, inv_set;
    logic [1:0] clr_mask;

    assign cmd_wr = bus_req.wr && bus_req.addr == hacp_pkg::HACP_REG_CMD;
    assign din_rd = bus_req.rd &&
        bus_req.addr == hacp_pkg::HACP_REG_DATA_IN;
    // scan start is taken in any state but parameter collection
    assign scan_req = cmd_wr && bus_req.wdata == hacp_pkg::HACP_OP_SCAN &&
        state_r != hacp_pkg::HACP_PARAM;
    assign adapter_ready = state_r == hacp_pkg::HACP_IDLE;
    assign irq_any = |(ist_r & ien_r);
    assign bus_rdata = rdata_r;
    assign scan_out = scan_r;

    // one line of six carries the level interrupt
    genvar gi;
    generate
        for (gi = 0; gi < hacp_pkg::HACP_NUM_IRQ; gi++) begin : g_irq
            assign irq_lines[gi] = irq_any &&
                irqsel_r == 3'(gi);
        end
    endgenerate

    function automatic logic [7:0] id_byte(input logic [1:0] i);
        case (i)
            2'h0: id_byte = hacp_pkg::HACP_ID_BOARD;
            2'h1: id_byte = hacp_pkg::HACP_ID_FEAT;
            2'h2: id_byte = hacp_pkg::HACP_ID_FW_REV;
            default: id_byte = hacp_pkg::HACP_ID_FW_VER;
        endcase
    endfunction : id_byte

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        npar_nxt = npar_r;
        pidx_nxt = pidx_r;
        cnt_nxt = cnt_r;
        base_nxt = base_r;
        pbuf_nxt = pbuf_r;
        mbox_init_nxt = mbox_init_r;
        init_req_nxt = init_req_r;
        busy_nxt = cmd_wr;
        dir_rdy_nxt = dir_rdy_r;
        din_nxt = din_r;
        sidx_nxt = sidx_r;
        cc_set = 1'b0;
        inv_set = 1'b0;
        cnt_fin = (op_r == hacp_pkg::HACP_OP_INIT32) ? pbuf_r[31:24] :
            pbuf_r[23:16];
        base_fin = (op_r == hacp_pkg::HACP_OP_INIT32) ?
            {pbuf_r[23:0], bus_req.wdata} :
            {8'h00, pbuf_r[15:0], bus_req.wdata};
        case (state_r)
            hacp_pkg::HACP_IDLE: begin
                if (cmd_wr) begin
                    op_nxt = bus_req.wdata;
                    pidx_nxt = 3'h0;
                    pbuf_nxt = 32'h0000_0000;
                    sidx_nxt = 2'h0;
                    case (bus_req.wdata)
                        hacp_pkg::HACP_OP_TEST: cc_set = 1'b1;
                        hacp_pkg::HACP_OP_INIT: begin
                            state_nxt = hacp_pkg::HACP_PARAM;
                            npar_nxt = hacp_pkg::HACP_NPAR_INIT;
                        end
                        hacp_pkg::HACP_OP_INIT32: begin
                            state_nxt = hacp_pkg::HACP_PARAM;
                            npar_nxt = hacp_pkg::HACP_NPAR_INIT32;
                        end
                        hacp_pkg::HACP_OP_SCAN: ; // handled below
                        hacp_pkg::HACP_OP_BIOS: ;
                        hacp_pkg::HACP_OP_ID: begin
                            state_nxt = hacp_pkg::HACP_SEND;
                        end
                        8'h05, 8'h07, 8'h08, 8'h09: begin
                            state_nxt = hacp_pkg::HACP_PARAM;
                            npar_nxt = hacp_pkg::HACP_NPAR_ONE;
                        end
                        hacp_pkg::HACP_OP_SEL_TO: begin
                            state_nxt = hacp_pkg::HACP_PARAM;
                            npar_nxt = hacp_pkg::HACP_NPAR_FOUR;
                        end
                        8'h0A, 8'h0B, 8'h0D, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
                        8'h1F, 8'h20, 8'h21, 8'h8D: cc_set = 1'b1;
                        default: begin
                            cc_set = 1'b1;
                            inv_set = 1'b1;
                        end
                    endcase
                end
            end
            hacp_pkg::HACP_PARAM: begin
                if (cmd_wr) begin
                    pidx_nxt = pidx_r + 3'h1;
                    pbuf_nxt = {pbuf_r[23:0], bus_req.wdata};
                    if (pidx_r == npar_r - 3'h1) begin
                        state_nxt = hacp_pkg::HACP_IDLE;
                        if (op_r == hacp_pkg::HACP_OP_INIT ||
                            op_r == hacp_pkg::HACP_OP_INIT32) begin
                            cc_set = 1'b1;
                            if (cnt_fin == 8'h00) begin
                                inv_set = 1'b1;
                            end else begin
                                init_req_nxt = 1'b0;
                                mbox_init_nxt = 1'b1;
                                cnt_nxt = cnt_fin;
                                base_nxt = base_fin;
                            end
                        end else if (op_r == hacp_pkg::HACP_OP_OMB_EN) begin
                            if (bus_req.wdata > hacp_pkg::HACP_OMB_MAX) begin
                                cc_set = 1'b1;
                                inv_set = 1'b1;
                            end
                        end else begin
                            cc_set = 1'b1;
                        end
                    end
                end
            end
            hacp_pkg::HACP_SEND: begin
                if (!dir_rdy_r) begin
                    din_nxt = id_byte(sidx_r);
                    dir_rdy_nxt = 1'b1;
                end else if (din_rd) begin
                    dir_rdy_nxt = 1'b0;
                    if (sidx_r == hacp_pkg::HACP_ID_LAST) begin
                        state_nxt = hacp_pkg::HACP_IDLE;
                        cc_set = 1'b1;
                    end else begin
                        sidx_nxt = sidx_r + 2'h1;
                    end
                end
            end
            default: state_nxt = hacp_pkg::HACP_IDLE;
        endcase
        if (scan_req && !mbox_init_r) begin
            cc_set = 1'b1;
            inv_set = 1'b1;
        end
    end

    // outgoing mailbox walk, one entry per cycle
    always_comb begin
        scan_act_nxt = scan_act_r;
        sc_idx_nxt = sc_idx_r;
        scan_nxt.valid = 1'b0;
        scan_nxt.addr = scan_r.addr;
        if (scan_req && mbox_init_r) begin
            scan_act_nxt = 1'b1;
            sc_idx_nxt = 8'h00;
        end else if (scan_act_r) begin
            scan_nxt.valid = 1'b1;
            scan_nxt.addr = base_r +
                {22'h0, sc_idx_r, 2'h0};
            if (sc_idx_r == cnt_r - 8'h01) begin
                scan_act_nxt = 1'b0;
            end else begin
                sc_idx_nxt = sc_idx_r + 8'h01;
            end
        end
    end

    // interrupt flags, register reads and writes
    always_comb begin
        clr_mask = 2'h0;
        ien_nxt = ien_r;
        irqsel_nxt = irqsel_r;
        rdata_nxt = 8'h00;
        if (bus_req.wr) begin
            case (bus_req.addr)
                hacp_pkg::HACP_REG_INT_CLR: clr_mask = bus_req.wdata[1:0];
                hacp_pkg::HACP_REG_INT_EN: ien_nxt = bus_req.wdata[1:0];
                hacp_pkg::HACP_REG_IRQ_SEL: begin
                    if (bus_req.wdata[2:0] <= hacp_pkg::HACP_IRQ_SEL_MAX &&
                        bus_req.wdata[7:3] == 5'h00) begin
                        irqsel_nxt = bus_req.wdata[2:0];
                    end
                end
                default: ;
            endcase
        end
        // a set in the clearing cycle wins
        ist_nxt = (ist_r & ~clr_mask) | {inv_set, cc_set};
        if (bus_req.rd) begin
            case (bus_req.addr)
                hacp_pkg::HACP_REG_STATUS: rdata_nxt = {4'h0, init_req_r,
                    dir_rdy_r, busy_r, adapter_ready};
                hacp_pkg::HACP_REG_DATA_IN: rdata_nxt = din_r;
                hacp_pkg::HACP_REG_INT_STAT: rdata_nxt = {6'h00, ist_r};
                hacp_pkg::HACP_REG_INT_EN: rdata_nxt = {6'h00, ien_r};
                hacp_pkg::HACP_REG_IRQ_SEL: rdata_nxt = {5'h00, irqsel_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= hacp_pkg::HACP_IDLE;
            op_r <= 8'h00;
            npar_r <= 3'h0;
            pidx_r <= 3'h0;
            cnt_r <= 8'h00;
            base_r <= 32'h0000_0000;
            pbuf_r <= 32'h0000_0000;
            mbox_init_r <= 1'b0;
            init_req_r <= 1'b1;
            busy_r <= 1'b0;
            dir_rdy_r <= 1'b0;
            din_r <= 8'h00;
            sidx_r <= 2'h0;
            ist_r <= 2'h0;
            ien_r <= 2'h0;
            irqsel_r <= hacp_pkg::HACP_IRQ_SEL_RST;
            rdata_r <= 8'h00;
            scan_act_r <= 1'b0;
            sc_idx_r <= 8'h00;
            scan_r <= '0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            npar_r <= npar_nxt;
            pidx_r <= pidx_nxt;
            cnt_r <= cnt_nxt;
            base_r <= base_nxt;
            pbuf_r <= pbuf_nxt;
            mbox_init_r <= mbox_init_nxt;
            init_req_r <= init_req_nxt;
            busy_r <= busy_nxt;
            dir_rdy_r <= dir_rdy_nxt;
            din_r <= din_nxt;
            sidx_r <= sidx_nxt;
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            irqsel_r <= irqsel_nxt;
            rdata_r <= rdata_nxt;
            scan_act_r <= scan_act_nxt;
            sc_idx_r <= sc_idx_nxt;
            scan_r <= scan_nxt;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_op_idle(logic [7:0] op);
        cmd_wr && adapter_ready && bus_req.wdata == op;
    endsequence
    sequence s_last_init;
        cmd_wr && state_r == hacp_pkg::HACP_PARAM &&
            op_r == hacp_pkg::HACP_OP_INIT && pidx_r == 3'h3;
    endsequence

    a_test_sets_cc: assert property (s_op_idle(8'h00) |=> ist_r[0])
        else $error("test opcode did not set complete");
    a_busy_pulse: assert property (cmd_wr ##1 !cmd_wr |->
        busy_r ##1 !busy_r) else $error("busy flag not a single pulse");
    a_din_clear: assert property (dir_rdy_r && din_rd &&
        state_r == hacp_pkg::HACP_SEND |=> !dir_rdy_r)
        else $error("data-in ready not cleared by read");
    a_init_zero: assert property (s_last_init ##0 pbuf_r[23:16] == 8'h00 |=>
        ist_r == 2'h3 && init_req_r == $past(init_req_r))
        else $error("zero count not flagged invalid");
    a_init_done: assert property (s_last_init ##0 pbuf_r[23:16] != 8'h00 |=>
        ist_r[0] && !init_req_r && mbox_init_r)
        else $error("mailbox init did not complete");
    a_scan_quiet: assert property (scan_req && mbox_init_r &&
        !ist_r[0] && state_r == hacp_pkg::HACP_IDLE |=> !ist_r[0])
        else $error("accepted scan set complete");
    a_scan_uninit: assert property (scan_req && !mbox_init_r |=>
        ist_r == 2'h3)
        else $error("early scan not flagged invalid");
    a_entry_stride: assert property (scan_r.valid &&
        $past(scan_r.valid) |-> scan_r.addr == $past(scan_r.addr) + 32'h4)
        else $error("mailbox entries not four bytes apart");
    a_scan_ends: assert property (scan_req && mbox_init_r &&
        cnt_r == 8'h02 |=> scan_act_r ##1 scan_act_r ##1 !scan_act_r)
        else $error("scan did not cover every entry");
    a_id_bytes: assert property (s_op_idle(8'h04) |=>
        state_r == hacp_pkg::HACP_SEND ##1 dir_rdy_r && din_r == 8'h5A)
        else $error("identification not started");
    a_bad_opcode: assert property (s_op_idle(8'h0C) |=>
        ist_r == 2'h3 && adapter_ready)
        else $error("undecoded opcode not flagged invalid");
    a_irq_route: assert property ($onehot0(irq_lines) &&
        (|irq_lines == irq_any)) else $error("interrupt line routing wrong");
endmodule : hacp_command_port

// *** core/hacp_pkg.sv ***
// hacp_pkg: constants, states and carriers of the host command port
// assumes one 250 MHz clock domain and an 8-bit register port
package hacp_pkg;
    // register addresses on the command port
    localparam logic [2:0] HACP_REG_STATUS = 3'h0;
    localparam logic [2:0] HACP_REG_CMD = 3'h1;
    localparam logic [2:0] HACP_REG_DATA_IN = 3'h2;
    localparam logic [2:0] HACP_REG_INT_STAT = 3'h3;
    localparam logic [2:0] HACP_REG_INT_CLR = 3'h4;
    localparam logic [2:0] HACP_REG_INT_EN = 3'h5;
    localparam logic [2:0] HACP_REG_IRQ_SEL = 3'h6;
    // status register bits
    localparam int HACP_ST_READY = 0;
    localparam int HACP_ST_BUSY = 1;
    localparam int HACP_ST_DIR_RDY = 2;
    localparam int HACP_ST_INIT_REQ = 3;
    // interrupt register bits
    localparam int HACP_INT_CC = 0;
    localparam int HACP_INT_INV = 1;
    localparam int HACP_INT_W = 2;
    // opcodes
    localparam logic [7:0] HACP_OP_TEST = 8'h00;
    localparam logic [7:0] HACP_OP_INIT = 8'h01;
    localparam logic [7:0] HACP_OP_SCAN = 8'h02;
    localparam logic [7:0] HACP_OP_BIOS = 8'h03;
    localparam logic [7:0] HACP_OP_ID = 8'h04;
    localparam logic [7:0] HACP_OP_OMB_EN = 8'h05;
    localparam logic [7:0] HACP_OP_SEL_TO = 8'h06;
    localparam logic [7:0] HACP_OP_INIT32 = 8'h81;
    // parameter byte counts
    localparam logic [2:0] HACP_NPAR_INIT = 3'h4;
    localparam logic [2:0] HACP_NPAR_INIT32 = 3'h5;
    localparam logic [2:0] HACP_NPAR_ONE = 3'h1;
    localparam logic [2:0] HACP_NPAR_FOUR = 3'h4;
    // identification bytes: values arbitrary
    localparam logic [7:0] HACP_ID_BOARD = 8'h5A;
    localparam logic [7:0] HACP_ID_FEAT = 8'h5B;
    localparam logic [7:0] HACP_ID_FW_REV = 8'h31;
    localparam logic [7:0] HACP_ID_FW_VER = 8'h32;
    localparam logic [1:0] HACP_ID_LAST = 2'h3;
    // interrupt line selection: 9,10,11,12,14,15
    localparam int HACP_NUM_IRQ = 6;
    localparam logic [2:0] HACP_IRQ_SEL_RST = 3'h2;
    localparam logic [2:0] HACP_IRQ_SEL_MAX = 3'h5;
    // mailbox entry size shift (four bytes)
    localparam int HACP_MBOX_SHIFT = 2;
    localparam logic [7:0] HACP_OMB_MAX = 8'h01;

    typedef enum logic [1:0] {
        HACP_IDLE = 2'b00,
        HACP_PARAM = 2'b01,
        HACP_SEND = 2'b10
    } hacp_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } hacp_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } hacp_scan_t;
endpackage : hacp_pkg

// *** dv/hacp_command_port_tb.sv ***
// hacp_command_port_tb: register-level tests of the host command port
// assumes hacp_pkg and hacp_command_port compiled first, one clock
`timescale 1ns/1ns
module hacp_command_port_tb;
    logic sys_clk;
    logic resetn;
    hacp_pkg::hacp_bus_req_t req;
    logic [7:0] bus_rdata;
    logic [hacp_pkg::HACP_NUM_IRQ-1:0] irq_lines;
    hacp_pkg::hacp_scan_t scan_out;
    int err_total;
    int samples_checked;
    int cyc_count = 0;
    logic [7:0] rd_val;
    logic [31:0] scan_q[$];
    logic [7:0] id_exp[4];
    logic [7:0] ops[5];
    logic [7:0] ops_exp[5];

    hacp_command_port dut_u (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .bus_req(req),
        .bus_rdata(bus_rdata),
        .irq_lines(irq_lines),
        .scan_out(scan_out)
    );

    always #2 sys_clk = ~sys_clk;

    // collect visited outgoing mailbox entries
    always @(posedge sys_clk) begin
        if (scan_out.valid === 1'b1) begin
            scan_q.push_back(scan_out.addr);
        end
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 5000) begin
            err_total++;
            $display("[ERR] run timeout");
            tally_and_finish();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // write strobe stays up until the next task drives the bus
    task automatic bus_wr(logic [2:0] a, logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
    endtask : bus_wr

    task automatic bus_rd(logic [2:0] a, output logic [7:0] d);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1;
        d = bus_rdata;
        @(posedge sys_clk);
    endtask : bus_rd

    task automatic idle(int n);
        req <= '0;
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic rd_chk(string name, logic [2:0] a, logic [7:0] exp);
        logic [7:0] d;
        bus_rd(a, d);
        check(name, {24'h00_0000, d}, {24'h00_0000, exp});
    endtask : rd_chk

    // poll status until the masked bits match
    task automatic poll(logic [7:0] mask, logic [7:0] val);
        logic [7:0] d;
        int n;
        n = 0;
        d = 8'h00;
        bus_rd(hacp_pkg::HACP_REG_STATUS, d);
        while (((d & mask) !== val) && (n < 40)) begin
            bus_rd(hacp_pkg::HACP_REG_STATUS, d);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            $display("[ERR] status poll expected %0h seen %0h", val, d);
        end
    endtask : poll

    // mailbox init parameters: count, then base 12_3456 high byte first
    task automatic mbox_par(logic [7:0] cnt);
        for (int i = 0; i < 4; i++) begin
            poll(8'h02, 8'h00);
            bus_wr(hacp_pkg::HACP_REG_CMD,
                (i == 0) ? cnt : 8'(8'h22 * i - 8'h10));
        end
    endtask : mbox_par

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        req = '0;
        err_total = 0;
        samples_checked = 0;
        id_exp = '{hacp_pkg::HACP_ID_BOARD, hacp_pkg::HACP_ID_FEAT,
                   hacp_pkg::HACP_ID_FW_REV, hacp_pkg::HACP_ID_FW_VER};
        ops = '{8'h0D, 8'h20, 8'h8D, 8'h0C, 8'h22};
        ops_exp = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03};
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        // reset state: ready and init required
        rd_chk("status", hacp_pkg::HACP_REG_STATUS, 8'h09);
        rd_chk("int_stat", hacp_pkg::HACP_REG_INT_STAT, 8'h00);
        rd_chk("irq_sel", hacp_pkg::HACP_REG_IRQ_SEL, 8'h02);
        rd_chk("unmapped", 3'h7, 8'h00);
        check("irq_lines", {26'h000_0000, irq_lines}, 32'h0000_0000);
        // test opcode sets complete only
        bus_wr(hacp_pkg::HACP_REG_INT_EN, 8'h03);
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_TEST);
        rd_chk("int_test", hacp_pkg::HACP_REG_INT_STAT, 8'h01);
        for (int s = 0; s < 6; s++) begin
            bus_wr(hacp_pkg::HACP_REG_IRQ_SEL, 8'(s));
            idle(2);
            check("irq_line", {26'h000_0000, irq_lines}, 32'(1 << s));
        end
        bus_wr(hacp_pkg::HACP_REG_IRQ_SEL, 8'h06);
        rd_chk("irq_sel_bad", hacp_pkg::HACP_REG_IRQ_SEL, 8'h05);
        bus_wr(hacp_pkg::HACP_REG_IRQ_SEL, 8'h02);
        bus_wr(hacp_pkg::HACP_REG_INT_EN, 8'h00);
        idle(2);
        check("irq_masked", {26'h000_0000, irq_lines}, 32'h0000_0000);
        bus_wr(hacp_pkg::HACP_REG_INT_EN, 8'h03);
        bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h01);
        idle(2);
        check("irq_clr", {26'h000_0000, irq_lines}, 32'h0000_0000);
        // scan start before any mailbox init
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_SCAN);
        rd_chk("scan_early", hacp_pkg::HACP_REG_INT_STAT, 8'h03);
        check("scan_none", 32'(scan_q.size()), 32'h0000_0000);
        bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h03);
        // zero mailbox count
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_INIT);
        rd_chk("busy_op", hacp_pkg::HACP_REG_STATUS, 8'h0A);
        mbox_par(8'h00);
        rd_chk("init_zero", hacp_pkg::HACP_REG_INT_STAT, 8'h03);
        rd_chk("still_req", hacp_pkg::HACP_REG_STATUS, 8'h09);
        bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h03);
        // good init: two mailboxes, base 12_3456
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_INIT);
        mbox_par(8'h02);
        rd_chk("init_ok", hacp_pkg::HACP_REG_INT_STAT, 8'h01);
        rd_chk("init_done", hacp_pkg::HACP_REG_STATUS, 8'h01);
        bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h03);
        // scan visits two entries, four bytes apart, no complete
        scan_q.delete();
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_SCAN);
        idle(10);
        check("scan_cnt", 32'(scan_q.size()), 32'h0000_0002);
        check("scan_a0", scan_q[0], 32'h0012_3456);
        check("scan_a1", scan_q[1], 32'h0012_345A);
        rd_chk("scan_quiet", hacp_pkg::HACP_REG_INT_STAT, 8'h00);
        // board id, with a scan start issued while not ready
        scan_q.delete();
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_ID);
        for (int i = 0; i < 4; i++) begin
            poll(8'h04, 8'h04);
            bus_rd(hacp_pkg::HACP_REG_DATA_IN, rd_val);
            check("id_byte", {24'h00_0000, rd_val},
                {24'h00_0000, id_exp[i]});
            if (i == 0) begin
                bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_SCAN);
                idle(10);
                check("scan_busy", 32'(scan_q.size()),
                    32'h0000_0002);
            end
        end
        idle(2);
        rd_chk("id_done", hacp_pkg::HACP_REG_INT_STAT, 8'h01);
        rd_chk("id_idle", hacp_pkg::HACP_REG_STATUS, 8'h01);
        bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h03);
        // bios opcode stays silent
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_BIOS);
        idle(2);
        rd_chk("bios", hacp_pkg::HACP_REG_INT_STAT, 8'h00);
        // decoded versus undecoded opcodes
        for (int i = 0; i < 5; i++) begin
            poll(8'h01, 8'h01);
            bus_wr(hacp_pkg::HACP_REG_CMD, ops[i]);
            idle(2);
            rd_chk("decode", hacp_pkg::HACP_REG_INT_STAT, ops_exp[i]);
            bus_wr(hacp_pkg::HACP_REG_INT_CLR, 8'h03);
        end
        // one-parameter opcode with an out-of-range byte
        bus_wr(hacp_pkg::HACP_REG_CMD, hacp_pkg::HACP_OP_OMB_EN);
        poll(8'h02, 8'h00);
        bus_wr(hacp_pkg::HACP_REG_CMD, 8'h02);
        rd_chk("omb_bad", hacp_pkg::HACP_REG_INT_STAT, 8'h03);
        idle(2);
        tally_and_finish();
    end
endmodule : hacp_command_port_tb
